/* File: rtl/pefs_pkg.sv */
// shared constants for the port e function select block
package pefs_pkg;
  // register index as printed, byte address is four times it
  localparam logic [7:0]  FSEL_IDX  = 8'h0A;
  localparam logic [31:0] FSEL_ADDR = {22'h0, FSEL_IDX, 2'h0};
  // bit positions inside the select register
  localparam int B_FREE  = 7;
  localparam int B_QUEUE = 5;
  localparam int B_BUS_PHASE_CLOCK  = 4;
  localparam int B_STRB  = 3;
  localparam int B_RW    = 2;
  // implemented, write-once and clock-disable masks
  localparam logic [7:0] IMPL_MASK = 8'hBC;
  localparam logic [7:0] ONCE_MASK = 8'hAC;
  localparam logic [7:0] BUS_PHASE_CLOCK_MASK = 8'h10;
  // reset values by operating mode
  localparam logic [7:0] RST_SSC  = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h2C;
  localparam logic [7:0] RST_PERI = 8'h00;
  localparam logic [7:0] RST_EMU  = 8'hAC;
  localparam logic [7:0] RST_NSC  = 8'h10;
  localparam logic [7:0] RST_NX   = 8'h00;
  // operating mode field codes
  typedef enum logic [2:0] {
    MODE_SSC  = 3'h0,
    MODE_EMN  = 3'h1,
    MODE_TEST = 3'h2,
    MODE_EMW  = 3'h3,
    MODE_NSC  = 3'h4,
    MODE_NXN  = 3'h5,
    MODE_PERI = 3'h6,
    MODE_NXW  = 3'h7
  } op_mode_t;
  // bus phase clock timing
  localparam int CLK_MHZ       = 200;
  localparam int BUS_PHASE_CLOCK_HALF_NS  = 5;
  localparam int BUS_PHASE_CLOCK_HALF_CYC = (BUS_PHASE_CLOCK_HALF_NS * CLK_MHZ + 999) / 1000;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: rtl/pe_ctrl_if.sv */
// signals between the select register, clock maker and pin mux
`timescale 1ns/1ps
`default_nettype none
interface pe_ctrl_if;
  logic free_en;    // cpu free cycle on pin 7
  logic queue_en;   // queue status on pins 6:5
  logic bus_phase_clock_en;    // bus phase clock on pin 4
  logic strb_en;    // low byte strobe on pin 3
  logic rw_en;      // read/write on pin 2
  logic tag_act;    // debug tagging active
  logic bus_phase_clock;       // bus phase clock level
  logic bus_phase_clock_rise;  // pulse with the rising edge
  logic bus_phase_clock_fall;  // pulse with the falling edge
  modport ctrl (output free_en, queue_en, bus_phase_clock_en, strb_en, rw_en, tag_act);
  modport gen  (output bus_phase_clock, bus_phase_clock_rise, bus_phase_clock_fall);
  modport mux  (input free_en, queue_en, bus_phase_clock_en, strb_en, rw_en, tag_act, bus_phase_clock, bus_phase_clock_rise, bus_phase_clock_fall);
endinterface // pe_ctrl_if
`default_nettype wire

/* File: rtl/bus_clock_gen.sv */
// bus phase clock maker, free running or held between external cycles
`timescale 1ns/1ps
`default_nettype none
module bus_clock_gen #(
  parameter int HALF_CYC = pefs_pkg::BUS_PHASE_CLOCK_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_ce,
  // stretch control
  input  wire logic i_stretch_sel,
  input  wire logic i_ext_cycle,
  // clock out to the pins
  pe_ctrl_if.gen    pc
);
  if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
    $error("bus_clock_gen: HALF_CYC out of range");
  end
  logic [7:0] cnt_r;  // cycles into the current half period
  logic       bus_phase_clock_r;
  logic       rise_r;
  logic       fall_r;
  logic       flip;   // half period over and allowed to move
  // held only while stretched, idle and low
  assign flip = (cnt_r == 8'(HALF_CYC - 1)) && (!i_stretch_sel || i_ext_cycle || bus_phase_clock_r);
  // counter and level
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_r  <= 8'h00;
      bus_phase_clock_r <= 1'h0;
      rise_r <= 1'h0;
      fall_r <= 1'h0;
    end else if (i_ce) begin
      rise_r <= flip && !bus_phase_clock_r;
      fall_r <= flip && bus_phase_clock_r;
      if (flip) begin
        bus_phase_clock_r <= !bus_phase_clock_r;
        cnt_r  <= 8'h00;
      end else if (cnt_r != 8'(HALF_CYC - 1)) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
  assign pc.bus_phase_clock      = bus_phase_clock_r;
  assign pc.bus_phase_clock_rise = rise_r;
  assign pc.bus_phase_clock_fall = fall_r;
  free_run_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_ce && !i_stretch_sel && cnt_r == 8'(HALF_CYC - 1) |=> bus_phase_clock_r != $past(bus_phase_clock_r))
    else $error("bus phase clock did not toggle");
endmodule // bus_clock_gen
`default_nettype wire

/* File: rtl/port_e_pin_mux.sv */
// per-pin choice between port data and bus control functions
`timescale 1ns/1ps
`default_nettype none
module port_e_pin_mux (
  // clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_ce,
  // general purpose port side
  input  wire logic [7:2] i_port_e_data,
  input  wire logic [7:2] i_port_e_direction,
  // bus control sources
  input  wire logic       i_cpu_free_cycle,
  input  wire logic       i_queue_status_hi,
  input  wire logic       i_queue_status_lo,
  input  wire logic       i_low_byte_strobe,
  input  wire logic       i_rw,
  input  wire logic       i_pe_in3,
  // enables and clock
  pe_ctrl_if.mux          pc,
  // pins
  output logic [7:2]      o_pe_out,
  output logic [7:2]      o_pe_oe,
  output logic            o_low_tag_input
);
  logic [7:2] alt_en;     // pins given to a control function
  logic [7:2] alt_val;    // control function levels
  logic [7:2] oe_nxt;
  logic       tag_phase;  // strobe pin released for the tag
  logic       pin3_s1_r;
  logic       pin3_s2_r;
  assign alt_en  = {pc.free_en, pc.queue_en, pc.queue_en, pc.bus_phase_clock_en, pc.strb_en, pc.rw_en};
  assign alt_val = {i_cpu_free_cycle, i_queue_status_hi, i_queue_status_lo, pc.bus_phase_clock, i_low_byte_strobe, i_rw};
  assign tag_phase = pc.strb_en && pc.tag_act && pc.bus_phase_clock;
  // control function wins over the direction bit
  assign oe_nxt = (alt_en | i_port_e_direction) & ~{4'h0, tag_phase, 1'h0};
  // registered pin drive
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pe_out <= 6'h00;
      o_pe_oe  <= 6'h00;
    end else if (i_ce) begin
      o_pe_out <= (alt_en & alt_val) | (~alt_en & i_port_e_data);
      // while tagging, the strobe only moves with the falling clock pulse
      if (pc.strb_en && pc.tag_act && !pc.bus_phase_clock_fall) begin
        o_pe_out[3] <= o_pe_out[3];
      end
      o_pe_oe  <= oe_nxt;
    end
  end
  // pin 3 synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pin3_s1_r <= 1'h0;
      pin3_s2_r <= 1'h0;
    end else if (i_ce) begin
      pin3_s1_r <= i_pe_in3;
      pin3_s2_r <= pin3_s1_r;
    end
  end
  // tag caught at the rising clock edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_low_tag_input <= 1'h0;
    end else if (i_ce && pc.strb_en && pc.tag_act && pc.bus_phase_clock_rise) begin
      o_low_tag_input <= pin3_s2_r;
    end
  end
  override_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_ce && pc.rw_en |=> o_pe_oe[2] && o_pe_out[2] == $past(i_rw))
    else $error("read/write pin not driven by control function");
  tag_release_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_ce && pc.strb_en && pc.tag_act && pc.bus_phase_clock |=> !o_pe_oe[3])
    else $error("strobe pin driven during tag phase");
endmodule // port_e_pin_mux
`default_nettype wire

/* File: rtl/port_e_function_assignment.sv */
// port e function select register with bus slave and pin control
//
// Overview of operation
// - enabled control function overrides direction bit
// - normal single chip reset: only clock disabled
// - normal expanded reset: all zero, clock on
// - test and emulation reset enable bus signals
// - expanded and peripheral modes forward to bus
// - bit 7 low enables free cycle output
// - bit 5 enables queue status pins
// - free and queue enables off chip modes
// - bit 4 low routes clock to pin
// - clock free runs when stretch select low
// - bit 3 enables low byte strobe pin
// - tag sampled rising, strobe driven falling
// - strobe off single, peripheral, normal narrow modes
// - bit 2 enables read write pin
// - three bit field holds operating mode
`timescale 1ns/1ps
`default_nettype none
module port_e_function_assignment #(
  parameter int ADDR_W = 32
) (
  // clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_ce,
  // operating mode and bus timing
  input  wire logic [2:0]        i_operating_mode_field,
  input  wire logic              i_bus_clock_stretch_sel,
  input  wire logic              i_ext_cycle,
  input  wire logic              i_background_debug_tag,
  // axi4-lite write address
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  // axi4-lite write data
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  // axi4-lite write response
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  // axi4-lite read address
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  // axi4-lite read data
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  // external bus forwarding
  output logic                   o_ext_req,
  output logic                   o_ext_we,
  output logic [7:0]             o_ext_wdata,
  input  wire logic [7:0]        i_ext_rdata,
  // port e side
  input  wire logic [7:2]        i_port_e_data,
  input  wire logic [7:2]        i_port_e_direction,
  input  wire logic              i_cpu_free_cycle,
  input  wire logic              i_queue_status_hi,
  input  wire logic              i_queue_status_lo,
  input  wire logic              i_low_byte_strobe,
  input  wire logic              i_rw,
  input  wire logic              i_pe_in3,
  // pins and status
  output logic [7:2]             o_pe_out,
  output logic [7:2]             o_pe_oe,
  output logic                   o_low_tag_input,
  output logic                   o_bus_phase_clock,
  output logic [7:0]             o_port_e_function_select
);
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("port_e_function_assignment: ADDR_W must be 8 to 32");
  end

  // mode decode
  pefs_pkg::op_mode_t mode;  // current operating mode
  logic is_special;          // special single, test, peripheral
  logic is_emu;              // emulation narrow or wide
  logic is_normal;           // normal single, narrow, wide
  logic chip_mode;           // single chip or peripheral
  logic absent;              // register not in the on-chip map

  // register state
  logic [7:0] pefs_r;        // the select register
  logic       once_used_r;   // write-once bits already spent
  logic [7:0] wmask;         // bits this write may change

  // write channel state
  logic              aw_have_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_have_r;
  logic [7:0]        w_data_r;
  logic              w_strb0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;

  // read channel state
  logic       rvalid_r;
  logic       rd_wait_r;     // waiting one cycle for external data
  logic [7:0] rdata_r;
  logic [1:0] rresp_r;

  // forwarding state
  logic       ext_req_r;
  logic       ext_we_r;
  logic [7:0] ext_wdata_r;

  // strobes
  logic wr_go;     // both halves of a write are held
  logic wr_hit;    // the write hits the select register
  logic reg_we;    // the register itself is written
  logic rd_take;   // read address taken this cycle
  logic rd_hit;    // the read hits the select register

  pe_ctrl_if pc ();

  // the mode field comes from the mode register on this clock
  assign mode = pefs_pkg::op_mode_t'(i_operating_mode_field);

  // mode classes
  always_comb begin
    is_special = 1'h0;
    is_emu     = 1'h0;
    is_normal  = 1'h0;
    case (mode)
      // special single chip, special test, special peripheral
      pefs_pkg::MODE_SSC,
      pefs_pkg::MODE_TEST,
      pefs_pkg::MODE_PERI: begin
        is_special = 1'h1;
      end
      // emulation narrow and wide
      pefs_pkg::MODE_EMN,
      pefs_pkg::MODE_EMW: begin
        is_emu = 1'h1;
      end
      // normal single chip, expanded narrow and wide
      default: begin
        is_normal = 1'h1;
      end
    endcase
  end

  assign chip_mode = (mode == pefs_pkg::MODE_SSC) || (mode == pefs_pkg::MODE_NSC) ||
                     (mode == pefs_pkg::MODE_PERI);
  // every expanded mode has the low mode bit set
  assign absent = i_operating_mode_field[0] || (mode == pefs_pkg::MODE_PERI);

  // reset value depends on the mode held at reset
  function automatic logic [7:0] rst_val(input pefs_pkg::op_mode_t m);
    case (m)
      pefs_pkg::MODE_SSC:  rst_val = pefs_pkg::RST_SSC;
      pefs_pkg::MODE_TEST: rst_val = pefs_pkg::RST_TEST;
      pefs_pkg::MODE_PERI: rst_val = pefs_pkg::RST_PERI;
      pefs_pkg::MODE_EMN,
      pefs_pkg::MODE_EMW:  rst_val = pefs_pkg::RST_EMU;
      pefs_pkg::MODE_NSC:  rst_val = pefs_pkg::RST_NSC;
      default:             rst_val = pefs_pkg::RST_NX;
    endcase
  endfunction

  // writable bits by mode class
  always_comb begin
    wmask = 8'h00;
    if (is_special) begin
      // special single chip and test write every implemented bit at any time
      wmask = pefs_pkg::IMPL_MASK;
    end else if (is_normal) begin
      // clock disable any time, the rest only once
      wmask = pefs_pkg::BUS_PHASE_CLOCK_MASK;
      if (!once_used_r) begin
        wmask = pefs_pkg::BUS_PHASE_CLOCK_MASK | pefs_pkg::ONCE_MASK;
      end
    end
    // emulation leaves the mask clear: no bit is writable
  end

  // bus strobes
  assign wr_go   = i_ce && aw_have_r && w_have_r && !bvalid_r;
  assign wr_hit  = aw_addr_r == pefs_pkg::FSEL_ADDR[ADDR_W-1:0];
  assign reg_we  = wr_go && wr_hit && !absent && w_strb0_r;
  assign rd_take = i_arvalid && o_arready;
  assign rd_hit  = i_araddr == pefs_pkg::FSEL_ADDR[ADDR_W-1:0];

  // ready terms; a read waits while a write is about to fire
  assign o_awready = i_ce && !aw_have_r && !bvalid_r;
  assign o_wready  = i_ce && !w_have_r && !bvalid_r;
  assign o_arready = i_ce && !rvalid_r && !rd_wait_r && !(aw_have_r && w_have_r);

  // select register and write-once tracking
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pefs_r      <= rst_val(mode);
      once_used_r <= 1'h0;
    end else if (reg_we) begin
      // unimplemented bits never leave zero
      pefs_r <= (pefs_r & ~wmask) | (w_data_r & wmask);
      if (is_normal) begin
        once_used_r <= 1'h1;
      end
    end
  end

  // write address and data capture, in either order
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_have_r <= 1'h0;
      aw_addr_r <= '0;
      w_have_r  <= 1'h0;
      w_data_r  <= 8'h00;
      w_strb0_r <= 1'h0;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_have_r <= 1'h1;
        aw_addr_r <= i_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'h0;
      end
      if (i_wvalid && o_wready) begin
        w_have_r  <= 1'h1;
        w_data_r  <= i_wdata[7:0];
        w_strb0_r <= i_wstrb[0];
      end else if (wr_go) begin
        w_have_r <= 1'h0;
      end
    end
  end

  // write response
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bvalid_r <= 1'h0;
      bresp_r  <= pefs_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (wr_go) begin
        bvalid_r <= 1'h1;
        // unmapped addresses get a decode error
        bresp_r  <= wr_hit ? pefs_pkg::RESP_OKAY : pefs_pkg::RESP_DECERR;
      end else if (i_bready) begin
        bvalid_r <= 1'h0;
      end
    end
  end

  // read path; a forwarded read answers one cycle later
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rvalid_r  <= 1'h0;
      rd_wait_r <= 1'h0;
      rdata_r   <= 8'h00;
      rresp_r   <= pefs_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (rd_take) begin
        rresp_r <= rd_hit ? pefs_pkg::RESP_OKAY : pefs_pkg::RESP_DECERR;
        if (rd_hit && absent) begin
          rd_wait_r <= 1'h1;
        end else begin
          rvalid_r <= 1'h1;
          // live value of every implemented bit
          rdata_r  <= rd_hit ? pefs_r : 8'h00;
        end
      end else if (rd_wait_r) begin
        rd_wait_r <= 1'h0;
        rvalid_r  <= 1'h1;
        rdata_r   <= i_ext_rdata;
      end else if (i_rready) begin
        rvalid_r <= 1'h0;
      end
    end
  end

  // accesses to the absent register go out on the external bus
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ext_req_r   <= 1'h0;
      ext_we_r    <= 1'h0;
      ext_wdata_r <= 8'h00;
    end else if (i_ce) begin
      ext_req_r <= 1'h0;
      if (wr_go && wr_hit && absent) begin
        ext_req_r   <= 1'h1;
        ext_we_r    <= 1'h1;
        ext_wdata_r <= w_data_r;
      end else if (rd_take && rd_hit && absent) begin
        ext_req_r <= 1'h1;
        ext_we_r  <= 1'h0;
      end
    end
  end

  // effective pin functions; chip modes have no external bus
  assign pc.free_en  = !pefs_r[pefs_pkg::B_FREE] && !chip_mode;
  assign pc.queue_en = pefs_r[pefs_pkg::B_QUEUE] && !chip_mode;
  assign pc.bus_phase_clock_en  = !pefs_r[pefs_pkg::B_BUS_PHASE_CLOCK];
  assign pc.strb_en  = pefs_r[pefs_pkg::B_STRB] && !chip_mode && (mode != pefs_pkg::MODE_NXN);
  assign pc.rw_en    = pefs_r[pefs_pkg::B_RW] && !chip_mode;
  assign pc.tag_act  = i_background_debug_tag;

  // bus phase clock maker
  bus_clock_gen u_clk (
    .i_clk         (i_clk),
    .i_reset_n     (i_reset_n),
    .i_ce          (i_ce),
    .i_stretch_sel (i_bus_clock_stretch_sel),
    .i_ext_cycle   (i_ext_cycle),
    .pc            (pc.gen)
  );

  // pin multiplexer
  port_e_pin_mux u_mux (
    .i_clk              (i_clk),
    .i_reset_n          (i_reset_n),
    .i_ce               (i_ce),
    .i_port_e_data      (i_port_e_data),
    .i_port_e_direction (i_port_e_direction),
    .i_cpu_free_cycle   (i_cpu_free_cycle),
    .i_queue_status_hi  (i_queue_status_hi),
    .i_queue_status_lo  (i_queue_status_lo),
    .i_low_byte_strobe  (i_low_byte_strobe),
    .i_rw               (i_rw),
    .i_pe_in3           (i_pe_in3),
    .pc                 (pc.mux),
    .o_pe_out           (o_pe_out),
    .o_pe_oe            (o_pe_oe),
    .o_low_tag_input    (o_low_tag_input)
  );

  // outputs
  assign o_bvalid                 = bvalid_r;
  assign o_bresp                  = bresp_r;
  assign o_rvalid                 = rvalid_r;
  assign o_rdata                  = {24'h0, rdata_r};
  assign o_rresp                  = rresp_r;
  assign o_ext_req                = ext_req_r;
  assign o_ext_we                 = ext_we_r;
  assign o_ext_wdata              = ext_wdata_r;
  assign o_bus_phase_clock        = pc.bus_phase_clock;
  assign o_port_e_function_select = pefs_r;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence rst_in_s(pefs_pkg::op_mode_t m);
    $past(!i_reset_n) && $past(mode) == m;
  endsequence
  sequence fwd_wr_s;
    wr_go && wr_hit && absent;
  endsequence
  sequence reg_rd_s;
    rd_take && rd_hit && !absent;
  endsequence

  nsc_reset_a: assert property (rst_in_s(pefs_pkg::MODE_NSC) |-> pefs_r == pefs_pkg::RST_NSC)
    else $error("normal single chip reset value wrong");
  nx_reset_a: assert property (rst_in_s(pefs_pkg::MODE_NXW) or rst_in_s(pefs_pkg::MODE_NXN)
    |-> pefs_r == pefs_pkg::RST_NX)
    else $error("normal expanded reset value wrong");
  emu_reset_a: assert property (rst_in_s(pefs_pkg::MODE_EMN) or rst_in_s(pefs_pkg::MODE_EMW)
    |-> pefs_r == pefs_pkg::RST_EMU)
    else $error("emulation reset value wrong");
  ext_fwd_a: assert property (fwd_wr_s |=> o_ext_req && o_ext_we && $stable(pefs_r))
    else $error("absent register write not forwarded");
  emu_lock_a: assert property (is_emu && $past(is_emu) && $past(i_reset_n) |-> $stable(pefs_r))
    else $error("register changed in emulation mode");
  once_only_a: assert property (is_normal && once_used_r ##1 is_normal
    |-> (pefs_r & pefs_pkg::ONCE_MASK) == ($past(pefs_r) & pefs_pkg::ONCE_MASK))
    else $error("write-once bit changed twice");
  chip_off_a: assert property (chip_mode |-> !pc.free_en && !pc.queue_en && !pc.rw_en)
    else $error("bus control enabled in chip mode");
  narrow_strb_a: assert property (mode == pefs_pkg::MODE_NXN |-> !pc.strb_en)
    else $error("strobe enabled in narrow mode");
  bus_phase_clock_write_a: assert property (reg_we && is_normal |=> pefs_r[4] == $past(w_data_r[4]))
    else $error("clock disable bit not written");
  read_value_a: assert property (reg_rd_s |=> o_rvalid && o_rdata[7:0] == $past(pefs_r))
    else $error("register read returned wrong value");
endmodule // port_e_function_assignment
`default_nettype wire

/* File: test/ext_bus_model.sv */
// external bus device answering forwarded register accesses
`timescale 1ns/1ps
`default_nettype none
module ext_bus_model (
  // forwarded access from the block
  input  wire logic       i_clk,
  input  wire logic       i_ext_req,
  input  wire logic       i_ext_we,
  input  wire logic [7:0] i_ext_wdata,
  // data back to the block
  output logic [7:0]      o_ext_rdata
);
  logic [7:0] mem_r = 8'h00;  // stored byte
  // keep forwarded writes
  always_ff @(posedge i_clk) begin
    if (i_ext_req && i_ext_we) mem_r <= i_ext_wdata;
  end
  // valid only in the request cycle, inverse otherwise so stale data never passes
  assign o_ext_rdata = (i_ext_req && !i_ext_we) ? mem_r : ~mem_r;
endmodule // ext_bus_model
`default_nettype wire

/* File: test/port_e_function_assignment_tb_top.sv */
// bench for the port e function select block
`timescale 1ns/1ps
`default_nettype none
module port_e_function_assignment_tb_top;
  logic i_clk, i_reset_n, i_ce, i_bus_clock_stretch_sel, i_ext_cycle, i_background_debug_tag, i_pe_in3;
  logic [2:0] i_operating_mode_field;
  logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, rd_d;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic o_ext_req, o_ext_we, o_low_tag_input, o_bus_phase_clock, c1;
  logic [7:0] o_ext_wdata, i_ext_rdata, o_port_e_function_select;
  logic [7:2] i_port_e_data, i_port_e_direction, o_pe_out, o_pe_oe;
  logic i_cpu_free_cycle, i_queue_status_hi, i_queue_status_lo, i_low_byte_strobe, i_rw;
  int bad_count = 0;
  int samples_checked = 0;
  // reset value per mode code
  logic [7:0] rv [8] = '{8'h00, 8'hAC, 8'h2C, 8'hAC, 8'h10, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] A = pefs_pkg::FSEL_ADDR;
  port_e_function_assignment dut (.i_clk, .i_reset_n, .i_ce, .i_operating_mode_field, .i_bus_clock_stretch_sel,
    .i_ext_cycle, .i_background_debug_tag, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
    .o_rresp, .o_ext_req, .o_ext_we, .o_ext_wdata, .i_ext_rdata, .i_port_e_data, .i_port_e_direction,
    .i_cpu_free_cycle, .i_queue_status_hi, .i_queue_status_lo, .i_low_byte_strobe, .i_rw, .i_pe_in3, .o_pe_out,
    .o_pe_oe, .o_low_tag_input, .o_bus_phase_clock, .o_port_e_function_select);
  ext_bus_model ext (.i_clk(i_clk), .i_ext_req(o_ext_req), .i_ext_we(o_ext_we), .i_ext_wdata(o_ext_wdata),
    .o_ext_rdata(i_ext_rdata));
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict, single exit
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reset for 20 cycles with a mode held stable
  task automatic rst(input logic [2:0] m);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_operating_mode_field <= m;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    #1;
  endtask
  // axi-lite write, both halves offered together
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    logic aw, w, b;
    aw = 1'b1; w = 1'b1; b = 1'b1;
    @(posedge i_clk);
    i_awaddr <= a; i_wdata <= {24'h0, d}; i_wstrb <= s;
    i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
    while (aw || w || b) begin
      @(posedge i_clk);
      if (aw && o_awready) begin aw = 1'b0; i_awvalid <= 1'b0; end
      if (w && o_wready) begin w = 1'b0; i_wvalid <= 1'b0; end
      if (b && o_bvalid) begin b = 1'b0; i_bready <= 1'b0; rsp = o_bresp; end
    end
    #1;
  endtask
  // axi-lite read
  task automatic rd(input logic [31:0] a);
    logic ar, r;
    ar = 1'b1; r = 1'b1;
    @(posedge i_clk);
    i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
    while (ar || r) begin
      @(posedge i_clk);
      if (ar && o_arready) begin ar = 1'b0; i_arvalid <= 1'b0; end
      if (r && o_rvalid) begin r = 1'b0; i_rready <= 1'b0; rd_d = o_rdata; rsp = o_rresp; end
    end
    #1;
  endtask
  // hang guard, far beyond the few hundred cycles used
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // main sequence
  initial begin
    i_reset_n = 1'b0; i_ce = 1'b1; i_operating_mode_field = 3'h4; i_bus_clock_stretch_sel = 1'b0;
    i_ext_cycle = 1'b0; i_background_debug_tag = 1'b0; i_pe_in3 = 1'b0; i_awvalid = 1'b0; i_wvalid = 1'b0;
    i_bready = 1'b0; i_arvalid = 1'b0; i_rready = 1'b0; i_awaddr = 32'h0; i_wdata = 32'h0; i_araddr = 32'h0;
    i_wstrb = 4'hF; i_port_e_data = 6'h00; i_port_e_direction = 6'h00; i_cpu_free_cycle = 1'b1;
    i_queue_status_hi = 1'b1; i_queue_status_lo = 1'b0; i_low_byte_strobe = 1'b1; i_rw = 1'b1;
    for (int m = 0; m < 8; m++) begin
      rst(m[2:0]);
      chk(o_port_e_function_select, rv[m]);
    end
    // normal single chip: write once, bit 4 stays free
    rst(pefs_pkg::MODE_NSC);
    rd(A); chk(rd_d, 32'h10);
    wr(A, 8'hFF, 4'hF);
    chk(rsp, pefs_pkg::RESP_OKAY);
    rd(A); chk(rd_d, 32'hBC);
    wr(A, 8'h00, 4'hF); rd(A); chk(rd_d, 32'hAC);
    chk(o_pe_oe, 6'b000100);
    rd(A + 32'h4); chk(rsp, pefs_pkg::RESP_DECERR);
    // special test: lane strobe off, then write anytime
    rst(pefs_pkg::MODE_TEST);
    wr(A, 8'h00, 4'h0); rd(A); chk(rd_d, 32'h2C);
    wr(A, 8'h00, 4'hF); rd(A); chk(rd_d, 32'h00);
    wr(A, 8'h3C, 4'hF); rd(A); chk(rd_d, 32'h3C);
    chk(o_pe_oe, 6'b111011);
    chk({o_pe_out[6:5], o_pe_out[3:2]}, 4'b1011);
    // tagging: strobe pin let go while the clock is high, tag caught from pin 3
    @(posedge i_clk);
    i_background_debug_tag <= 1'b1;
    i_pe_in3 <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1 c1 = o_pe_oe[3];
    @(posedge i_clk);
    #1 chk(o_pe_oe[3], {~c1});
    chk(o_low_tag_input, 1'b1);
    // emulation: write never
    rst(pefs_pkg::MODE_EMN);
    wr(A, 8'h00, 4'hF); chk(o_port_e_function_select, 8'hAC);
    // normal expanded wide: forwarded, clock free running
    rst(pefs_pkg::MODE_NXW);
    wr(A, 8'h5A, 4'hF); chk(o_port_e_function_select, 8'h00);
    chk({o_ext_we, o_ext_wdata}, 9'h15A);
    rd(A); chk(rd_d, 32'h5A);
    @(posedge i_clk); #1 c1 = o_bus_phase_clock;
    @(posedge i_clk); #1 chk(o_bus_phase_clock, {~c1});
    chk(o_pe_oe[4], 1'b1);
    // stretched with no external cycle: the clock parks low
    @(posedge i_clk);
    i_bus_clock_stretch_sel <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk(o_bus_phase_clock, 1'b0);
    tally_and_finish();
  end
endmodule // port_e_function_assignment_tb_top
`default_nettype wire
